// ### rtl/mov_pkg.sv
package mov_pkg;
  localparam int ADDR_W   = 32;
  localparam int DATA_W   = 32;
  localparam int DOM_W    = 2;
  localparam int SB_DEPTH = 4;
  localparam int SB_IDX_W = 2;

  typedef enum logic [1:0] {OP_LOAD = 2'b00, OP_STORE = 2'b01, OP_SEM = 2'b10, OP_FENCE = 2'b11} op_e;
  typedef enum logic [1:0] {ORD_UNORD = 2'b00, ORD_ACQ = 2'b01, ORD_REL = 2'b10} ord_e;
  typedef enum logic [1:0] {
    WRITEBACK_ATTR         = 2'b00,
    STRICT_UNCACHED_ATTR   = 2'b01,
    UNCACHED_EXPORTED_ATTR = 2'b10
  } attr_e;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_COH = 2'b01, ST_PER = 2'b10} fsm_e;

  typedef struct packed {
    op_e               op;
    ord_e              ord;
    attr_e             attr;
    logic [DOM_W-1:0]  dom;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mem_req_s;

  typedef struct packed {
    logic              rel;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sb_entry_s;

  typedef struct packed {
    fsm_e                         fsm;
    sb_entry_s [SB_DEPTH-1:0]     sb;
    logic [SB_IDX_W-1:0]          head;
    logic [SB_IDX_W-1:0]          tail;
    logic [SB_IDX_W:0]            count;
    logic                         coh_valid;
    logic                         coh_drain;
    mem_req_s                     coh;
    logic                         per_valid;
    mem_req_s                     per;
    logic                         rsp_valid;
    logic [DATA_W-1:0]            rsp_data;
  } unit_s;
endpackage

// ### rtl/mem_order_unit.sv
// Notes on behaviour
// - Release stores and semaphores reach the coherence domain one at a time in a single order.
// - A cacheable load may take its data from this unit's own store buffer before global visibility.
// - A cacheable store or semaphore after a release store becomes visible only after that release store.
// - Order is kept both for data read from another processor and for control dependencies.
// - A release store becomes visible through one single commit that all observers see at once.
// - A semaphore is also one single commit with the same causality as a release store.
// - Unordered stores need no extra wait and promise nothing to later operations.
// - An acquire load completes before any later operation of this processor is accepted.
// - Both uncached page attributes are handled as sequential memory.
// - Sequential accesses reach their peripheral domain in program order.
// - That program order holds for every ordering semantics, fence included.
// - Sequential accesses bypass the store buffer and are never seen by other observers here.
// - A sequential release store waits until all earlier stores are visible to the coherence domain.
// - Two unordered cacheable stores may become visible in either order; this unit drains them oldest first.
// - A sequential unordered store after a sequential release store stays behind it.
// - Semaphores are never served from nor forwarded out of the store buffer.
`timescale 1ns/1ps
module mem_order_unit
  import mov_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst,
  // Core request and response.
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire mem_req_s          req,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_data,
  // Coherence domain port.
  output logic                   coh_valid,
  output mem_req_s               coh_req,
  input  wire logic              coh_ack,
  input  wire logic [DATA_W-1:0] coh_rdata,
  // Peripheral domain port.
  output logic                   per_valid,
  output mem_req_s               per_req,
  input  wire logic              per_ack,
  input  wire logic [DATA_W-1:0] per_rdata,
  // Status.
  output logic                   sb_empty
);

  unit_s q;
  unit_s d;

  logic                is_cached;
  logic                sb_full;
  logic                coh_free;
  logic                fwd_hit;
  logic [DATA_W-1:0]   fwd_data;
  logic                can_go;
  logic                accept;
  logic                push;
  logic                pop;
  logic                fsm_takes_coh;
  logic [SB_IDX_W-1:0] idx;

  assign sb_empty  = (q.count == '0);
  assign sb_full   = (q.count == (SB_IDX_W+1)'(SB_DEPTH));
  assign coh_free  = !q.coh_valid;
  assign is_cached = (req.attr == WRITEBACK_ATTR);
  assign req_ready = (q.fsm == ST_IDLE) && can_go;
  assign accept    = req_valid && req_ready;
  assign rsp_valid = q.rsp_valid;
  assign rsp_data  = q.rsp_data;
  assign coh_valid = q.coh_valid;
  assign coh_req   = q.coh;
  assign per_valid = q.per_valid;
  assign per_req   = q.per;

  ////////////////////////////////////////////////////////////////////////////////
  // Forwarding search, oldest to youngest so the youngest match wins.
  always_comb begin
    fwd_hit  = 1'b0;
    fwd_data = '0;
    idx      = '0;
    for (int k = 0; k < SB_DEPTH; k++) begin
      idx = q.head + SB_IDX_W'(k);
      if ((SB_IDX_W+1)'(k) < q.count && q.sb[idx].addr == req.addr) begin
        fwd_hit  = 1'b1;
        fwd_data = q.sb[idx].data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Acceptance decision from the ordering and attribute tags.
  always_comb begin
    can_go = 1'b0;
    if (req.op == OP_FENCE) begin
      can_go = sb_empty && coh_free && !q.per_valid;
    end else if (!is_cached) begin
      // One sequential access in flight at a time keeps the peripheral domain in program order.
      if (req.ord == ORD_REL) begin
        can_go = sb_empty && coh_free;
      end else begin
        can_go = 1'b1;
      end
    end else begin
      case (req.op)
        OP_STORE: can_go = !sb_full;
        OP_LOAD:  can_go = fwd_hit || coh_free;
        OP_SEM:   can_go = sb_empty && coh_free;
        default:  can_go = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    d             = q;
    d.rsp_valid   = 1'b0;
    push          = 1'b0;
    pop           = 1'b0;
    fsm_takes_coh = 1'b0;
    case (q.fsm)
      ST_IDLE: begin
        if (accept) begin
          if (req.op == OP_FENCE) begin
            d.rsp_valid = 1'b1;
            d.rsp_data  = '0;
          end else if (!is_cached) begin
            d.per_valid = 1'b1;
            d.per       = req;
            d.fsm       = ST_PER;
          end else if (req.op == OP_STORE) begin
            push        = 1'b1;
            d.rsp_valid = 1'b1;
            d.rsp_data  = '0;
          end else if (req.op == OP_LOAD && fwd_hit) begin
            d.rsp_valid = 1'b1;
            d.rsp_data  = fwd_data;
          end else begin
            // Loads and semaphores wait for their data, so a control dependency cannot run ahead.
            fsm_takes_coh = 1'b1;
            d.coh_valid   = 1'b1;
            d.coh_drain   = 1'b0;
            d.coh         = req;
            d.fsm         = ST_COH;
          end
        end
      end
      ST_COH: begin
        if (coh_ack) begin
          d.coh_valid = 1'b0;
          d.rsp_valid = 1'b1;
          d.rsp_data  = coh_rdata;
          d.fsm       = ST_IDLE;
        end
      end
      ST_PER: begin
        if (per_ack) begin
          d.per_valid = 1'b0;
          d.rsp_valid = 1'b1;
          d.rsp_data  = per_rdata;
          d.fsm       = ST_IDLE;
        end
      end
      default: d.fsm = ST_IDLE;
    endcase

    // Drain is oldest first; unordered stores could pass each other but the single queue is cheaper.
    if (q.coh_valid && q.coh_drain && coh_ack) begin
      pop         = 1'b1;
      d.coh_valid = 1'b0;
    end else if (!q.coh_valid && !fsm_takes_coh && !sb_empty) begin
      d.coh_valid  = 1'b1;
      d.coh_drain  = 1'b1;
      d.coh.op     = OP_STORE;
      d.coh.ord    = q.sb[q.head].rel ? ORD_REL : ORD_UNORD;
      d.coh.attr   = WRITEBACK_ATTR;
      d.coh.dom    = '0;
      d.coh.addr   = q.sb[q.head].addr;
      d.coh.data   = q.sb[q.head].data;
    end

    if (push) begin
      d.sb[q.tail].rel  = (req.ord == ORD_REL);
      d.sb[q.tail].addr = req.addr;
      d.sb[q.tail].data = req.data;
      d.tail            = q.tail + SB_IDX_W'(1);
    end
    if (pop) begin
      d.head = q.head + SB_IDX_W'(1);
    end
    d.count = q.count + (SB_IDX_W+1)'(push) - (SB_IDX_W+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_sem_no_forward: assert property (
    accept && is_cached && req.op == OP_SEM |=> q.coh_valid && !q.coh_drain && !rsp_valid)
    else $error("semaphore did not go to the coherence port");
  a_sem_after_drain: assert property (
    accept && is_cached && req.op == OP_SEM |-> sb_empty && !q.coh_valid)
    else $error("semaphore issued with stores pending");
  a_rel_seq_wait: assert property (
    accept && !is_cached && req.ord == ORD_REL |-> sb_empty && !q.coh_valid)
    else $error("sequential release passed earlier stores");
  a_per_held: assert property (
    q.per_valid && !per_ack |=> q.per_valid && $stable(q.per))
    else $error("peripheral request changed before ack");
  a_per_single: assert property (
    q.per_valid |-> !req_ready)
    else $error("second sequential access accepted while one in flight");
  a_acq_blocks: assert property (
    accept && is_cached && req.op == OP_LOAD && !fwd_hit |=> !req_ready [*1] ##0 (q.fsm == ST_COH))
    else $error("acquire load did not block later operations");
  a_fwd_local: assert property (
    accept && is_cached && req.op == OP_LOAD && fwd_hit |=> rsp_valid && rsp_data == $past(fwd_data))
    else $error("forwarded load data wrong");
  a_seq_no_buffer: assert property (
    accept && !is_cached |=> q.count <= $past(q.count))
    else $error("sequential access entered the store buffer");
  a_drain_oldest: assert property (
    !q.coh_valid && !fsm_takes_coh && !sb_empty |=> q.coh_drain && q.coh.addr == $past(q.sb[q.head].addr))
    else $error("drain did not take the oldest store");
  a_fence_empty: assert property (
    accept && req.op == OP_FENCE |-> sb_empty && !q.coh_valid && !q.per_valid ##1 rsp_valid)
    else $error("fence completed with operations pending");

  c_sem_issue: cover property (accept && is_cached && req.op == OP_SEM);
  c_fwd_hit:   cover property (accept && is_cached && req.op == OP_LOAD && fwd_hit);
  c_seq_rel:   cover property (accept && !is_cached && req.ord == ORD_REL);
  c_sb_full:   cover property (sb_full);

endmodule

// ### bench/far_side_model.sv
`timescale 1ns/1ps
module far_side_model
  import mov_pkg::*;
(
  // Clock, reset and pace.
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              slow,
  // Coherence domain.
  input  wire logic              coh_valid,
  input  wire mem_req_s          coh_req,
  output logic                   coh_ack,
  output logic [DATA_W-1:0]      coh_rdata,
  // Peripheral domain.
  input  wire logic              per_valid,
  input  wire mem_req_s          per_req,
  output logic                   per_ack,
  output logic [DATA_W-1:0]      per_rdata
);
  logic [3:0]        cc_q;
  logic [3:0]        pc_q;
  logic [DATA_W-1:0] junk_q;
  logic              ca;
  logic              pa;
  wire  [3:0]        lim = slow ? 4'h5 : 4'h1;
  assign ca = coh_valid && !coh_ack && (cc_q + 4'h1 >= lim);
  assign pa = per_valid && !per_ack && (pc_q + 4'h1 >= lim);
  // Read data outside an answer keeps changing, so a stale capture cannot pass.
  assign coh_rdata = coh_ack ? ~coh_req.addr : junk_q;
  assign per_rdata = per_ack ? (per_req.addr ^ 32'h0000_FFFF) : ~junk_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      coh_ack <= 1'b0;
      per_ack <= 1'b0;
      cc_q    <= 4'h0;
      pc_q    <= 4'h0;
      junk_q  <= 32'h0000_0000;
    end else begin
      junk_q  <= junk_q + 32'h9E37_79B9;
      coh_ack <= ca;
      per_ack <= pa;
      cc_q    <= (coh_valid && !coh_ack && !ca) ? cc_q + 4'h1 : 4'h0;
      pc_q    <= (per_valid && !per_ack && !pa) ? pc_q + 4'h1 : 4'h0;
    end
  end
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import mov_pkg::*;
;
  logic              clk, rst, req_valid, req_ready, rsp_valid, slow;
  logic              coh_valid, coh_ack, per_valid, per_ack, sb_empty;
  logic [DATA_W-1:0] rsp_data, coh_rdata, per_rdata;
  mem_req_s          req, coh_req, per_req;
  int                error_cnt, n_compared, cyc;
  logic [ADDR_W-1:0] coh_q[$], per_q[$];

  mem_order_unit u_dut (.clk, .rst, .req_valid, .req_ready, .req, .rsp_valid, .rsp_data, .coh_valid,
                        .coh_req, .coh_ack, .coh_rdata, .per_valid, .per_req, .per_ack, .per_rdata, .sb_empty);
  far_side_model u_far (.clk, .rst, .slow, .coh_valid, .coh_req, .coh_ack, .coh_rdata,
                        .per_valid, .per_req, .per_ack, .per_rdata);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("errors=%0d compared=%0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic mem_req_s mk(op_e o, ord_e d, attr_e a, logic [ADDR_W-1:0] ad, logic [DATA_W-1:0] dt);
    mk = '{op: o, ord: d, attr: a, dom: 2'h1, addr: ad, data: dt};
  endfunction

  // Ready is combinational, so it is sampled at the falling edge where it has settled.
  task automatic xfer(input mem_req_s r, input logic [DATA_W-1:0] exp);
    int i;
    @(posedge clk) begin
      req       <= r;
      req_valid <= 1'b1;
    end
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (req_ready !== 1'b1 && i < 200);
    // A wait that runs out is a mismatch, not a silent skip.
    if (req_ready !== 1'b1) error_cnt++;
    @(posedge clk) req_valid <= 1'b0;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (rsp_valid !== 1'b1 && i < 200);
    if (rsp_valid !== 1'b1) error_cnt++;
    chk(rsp_data, exp);
  endtask

  task automatic wait_empty;
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (sb_empty !== 1'b1 && i < 200);
    if (sb_empty !== 1'b1) error_cnt++;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (coh_valid && coh_ack) coh_q.push_back(coh_req.addr);
    if (per_valid && per_ack) per_q.push_back(per_req.addr);
    if (per_valid && per_req.ord == ORD_REL) chk({31'h0, sb_empty}, 32'h1);
    if (cyc > 20000) begin
      error_cnt++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_forward;
    slow <= 1'b1;
    xfer(mk(OP_STORE, ORD_UNORD, WRITEBACK_ATTR, 32'h10, 32'hCAFE), 32'h0);
    xfer(mk(OP_LOAD, ORD_UNORD, WRITEBACK_ATTR, 32'h10, 32'h0), 32'hCAFE);
    chk({31'h0, sb_empty}, 32'h0);
    wait_empty();
  endtask

  task automatic t_sem;
    slow <= 1'b0;
    xfer(mk(OP_STORE, ORD_UNORD, WRITEBACK_ATTR, 32'h20, 32'h1234), 32'h0);
    xfer(mk(OP_SEM, ORD_ACQ, WRITEBACK_ATTR, 32'h20, 32'h1), 32'hFFFF_FFDF);
    xfer(mk(OP_LOAD, ORD_UNORD, WRITEBACK_ATTR, 32'h20, 32'h0), 32'hFFFF_FFDF);
  endtask

  task automatic t_rel;
    coh_q.delete();
    xfer(mk(OP_STORE, ORD_REL, WRITEBACK_ATTR, 32'h60, 32'h1), 32'h0);
    xfer(mk(OP_STORE, ORD_UNORD, WRITEBACK_ATTR, 32'h64, 32'h2), 32'h0);
    wait_empty();
    chk(coh_q[0], 32'h60);
    chk(coh_q[1], 32'h64);
  endtask

  // Sequential traffic must never show up on the coherence side.
  task automatic t_seq;
    slow <= 1'b1;
    coh_q.delete();
    per_q.delete();
    xfer(mk(OP_STORE, ORD_UNORD, WRITEBACK_ATTR, 32'h30, 32'h3), 32'h0);
    xfer(mk(OP_STORE, ORD_UNORD, WRITEBACK_ATTR, 32'h34, 32'h4), 32'h0);
    xfer(mk(OP_STORE, ORD_REL, STRICT_UNCACHED_ATTR, 32'h40, 32'h5), 32'h0000_FFBF);
    xfer(mk(OP_STORE, ORD_UNORD, UNCACHED_EXPORTED_ATTR, 32'h44, 32'h6), 32'h0000_FFBB);
    xfer(mk(OP_LOAD, ORD_ACQ, STRICT_UNCACHED_ATTR, 32'h48, 32'h0), 32'h0000_FFB7);
    wait_empty();
    chk(per_q[0], 32'h40);
    chk(per_q[1], 32'h44);
    chk(per_q[2], 32'h48);
    chk(32'(coh_q.size()), 32'h2);
  endtask

  task automatic t_fence;
    xfer(mk(OP_STORE, ORD_UNORD, WRITEBACK_ATTR, 32'h70, 32'h7), 32'h0);
    xfer(mk(OP_FENCE, ORD_UNORD, WRITEBACK_ATTR, 32'h0, 32'h0), 32'h0);
    chk({31'h0, sb_empty}, 32'h1);
    xfer(mk(OP_LOAD, ORD_ACQ, WRITEBACK_ATTR, 32'h50, 32'h0), 32'hFFFF_FFAF);
  endtask

  // Five stores to one address against four entries: the buffer fills after the fourth, and the first drain frees a slot before the fifth.
  task automatic t_full;
    slow <= 1'b1;
    coh_q.delete();
    for (int k = 0; k < 5; k++) begin
      xfer(mk(OP_STORE, ORD_UNORD, WRITEBACK_ATTR, 32'h80, 32'(k + 1)), 32'h0);
    end
    xfer(mk(OP_LOAD, ORD_UNORD, WRITEBACK_ATTR, 32'h80, 32'h0), 32'h5);
    wait_empty();
    chk(32'(coh_q.size()), 32'h5);
  endtask

  initial begin
    rst        = 1'b1;
    req_valid  = 1'b0;
    req        = '0;
    slow       = 1'b0;
    error_cnt  = 0;
    n_compared = 0;
    cyc        = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_forward();
    t_sem();
    t_rel();
    t_seq();
    t_fence();
    t_full();
    test_done();
  end
endmodule
